// ===== verilog/rci_defs.svh
// register offsets, reset values, field positions and timing counts for reset cause block
`ifndef RCI_DEFS_SVH
`define RCI_DEFS_SVH

`define RCI_OFF_INDIRECT_DATA_PORT_PORT 8'h00
`define RCI_OFF_TIMER 8'h01
`define RCI_OFF_PC_LOW 8'h02
`define RCI_OFF_FLAGS 8'h03
`define RCI_OFF_POINTER 8'h04
`define RCI_OFF_PA_DATA 8'h05
`define RCI_OFF_PB_DATA 8'h06
`define RCI_OFF_PC_DATA 8'h07
`define RCI_OFF_PC_HIGH 8'h0A
`define RCI_OFF_INT_CTRL 8'h0B
`define RCI_OFF_ACCUM 8'h0C
`define RCI_OFF_PIN_CFG 8'h0D
`define RCI_OFF_CORE_SET 8'h81
`define RCI_OFF_PA_DIR 8'h85
`define RCI_OFF_PB_DIR 8'h86
`define RCI_OFF_PC_DIR 8'h87
`define RCI_OFF_PWR_CTRL 8'h8E

`define RCI_BIT_POWER_ON 1
`define RCI_BIT_TIME_OUT 4
`define RCI_BIT_POWER_DOWN 3
`define RCI_BIT_GIE 7

`define RCI_RST_PC_LOW 8'h00
`define RCI_RST_PC_HIGH 5'h00
`define RCI_RST_CORE_SET 8'hFF
`define RCI_RST_PA_DIR 5'h1F
`define RCI_RST_PB_DIR 8'hFF
`define RCI_RST_PC_DIR 8'hFF
`define RCI_INT_VECTOR 8'h04

`define RCI_CLK_HZ 125000000
`define RCI_PWRUP_DELAY_MS 72
`define RCI_PWRUP_DELAY_CYC ((`RCI_PWRUP_DELAY_MS * 64'd125000000 + 999) / 1000)
`define RCI_OSC_START_CYC 1024

`endif

// ===== verilog/rci_pkg.sv
// types for the reset cause and initialisation block
`default_nettype none
package rci_pkg;
	typedef enum logic [1:0] {
		RCI_OSC_LOW_POWER,
		RCI_OSC_CRYSTAL,
		RCI_OSC_HIGH_SPEED,
		RCI_OSC_RES_CAP
	} rci_osc_mode_t;

	typedef enum logic [2:0] {
		RCI_EV_NONE,
		RCI_EV_POWER_ON,
		RCI_EV_EXT_RUN,
		RCI_EV_EXT_SLEEP,
		RCI_EV_WDOG_RUN,
		RCI_EV_WDOG_WAKE,
		RCI_EV_INT_WAKE
	} rci_event_t;
endpackage : rci_pkg
`default_nettype wire

// ===== verilog/rci_reset_init.sv
// reset cause recording, start-up delays and register initialisation
//
// How it works
// - power-on clears power flag, else kept
// - crystal modes: 72ms plus 1024 periods
// - resistor-capacitor mode: only 72ms delay
// - power-on: pc zero, flags 0001 1xxx
// - external reset running: clear upper three flags
// - external reset sleeping: flags 0001 0uuu
// - watchdog reset: flags 0000 uuuu
// - watchdog wake: next instruction, clear both
// - interrupt wake: time-out set, power-down clear
// - interrupt wake with enable: vector after next
// - power-on sets time-out and power-down
// - pc low zero on resets, next on wake
// - pc high latch zero, kept on wake
// - interrupt control upper seven cleared on reset
// - core settings all ones on reset
// - group A direction all ones on reset
// - groups B, C direction all ones
// - data registers kept across non-power resets
// - unused power control bits read zero
// - delay select set disables 72ms delay
// - oscillator delay only crystal, after power-up and on wake
`include "rci_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module rci_reset_init
	import rci_pkg::*;
#(
	parameter longint PWRUP_CYC = `RCI_PWRUP_DELAY_CYC,
	parameter int OSC_CYC = `RCI_OSC_START_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// reset events from the surrounding reset circuit
	input wire logic power_on_event,
	input wire logic external_reset_pin,
	input wire logic watchdog_event,
	input wire logic interrupt_wake,
	// core status
	input wire logic core_sleeping,
	input wire logic [7:0] next_pc,
	input wire logic [7:0] int_wake_flags,
	// configuration bits
	input wire logic power_up_delay_select,
	input wire rci_osc_mode_t osc_mode,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// core control
	output logic core_hold,
	output logic core_resume,
	output logic [7:0] pc_low,
	output logic [4:0] pc_high,
	output logic vector_pending
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: change counts once stages two and three agree
	logic [2:0] ext_sync_reg;
	logic [2:0] wdt_sync_reg;
	logic [2:0] int_sync_reg;
	logic ext_level_reg;
	logic wdt_level_reg;
	logic int_level_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext_sync_reg <= 3'h0;
			wdt_sync_reg <= 3'h0;
			int_sync_reg <= 3'h0;
			ext_level_reg <= 1'b0;
			wdt_level_reg <= 1'b0;
			int_level_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], external_reset_pin};
			wdt_sync_reg <= {wdt_sync_reg[1:0], watchdog_event};
			int_sync_reg <= {int_sync_reg[1:0], interrupt_wake};
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_level_reg <= ext_sync_reg[2];
			if (wdt_sync_reg[1] == wdt_sync_reg[2])
				wdt_level_reg <= wdt_sync_reg[2];
			if (int_sync_reg[1] == int_sync_reg[2])
				int_level_reg <= int_sync_reg[2];
		end
	end

	wire ext_rise = (ext_sync_reg[1] == ext_sync_reg[2]) & ext_sync_reg[2] & ~ext_level_reg;
	wire wdt_rise = (wdt_sync_reg[1] == wdt_sync_reg[2]) & wdt_sync_reg[2] & ~wdt_level_reg;
	wire int_rise = (int_sync_reg[1] == int_sync_reg[2]) & int_sync_reg[2] & ~int_level_reg;

	////////////////////////////////////////////////////////////////////////
	// event classification, power-on taken as sys_rst or the power event
	rci_event_t ev;
	wire por = sys_rst | power_on_event;
	assign ev = por ? RCI_EV_POWER_ON :
		ext_rise ? (core_sleeping ? RCI_EV_EXT_SLEEP : RCI_EV_EXT_RUN) :
		wdt_rise ? (core_sleeping ? RCI_EV_WDOG_WAKE : RCI_EV_WDOG_RUN) :
		(int_rise & core_sleeping) ? RCI_EV_INT_WAKE : RCI_EV_NONE;
	wire is_reset = (ev == RCI_EV_POWER_ON) | (ev == RCI_EV_EXT_RUN) |
		(ev == RCI_EV_EXT_SLEEP) | (ev == RCI_EV_WDOG_RUN);
	wire is_wake = (ev == RCI_EV_WDOG_WAKE) | (ev == RCI_EV_INT_WAKE);

	////////////////////////////////////////////////////////////////////////
	// start-up delay sequencer
	typedef enum logic [1:0] {RCI_ST_RUN, RCI_ST_PWRUP, RCI_ST_OSC} rci_seq_t;
	rci_seq_t seq_reg, seq_next;
	logic [31:0] cnt_reg, cnt_next;
	wire crystal = (osc_mode != RCI_OSC_RES_CAP);
	wire pwrup_on = ~power_up_delay_select;
	localparam logic [31:0] PWRUP_LAST = 32'(PWRUP_CYC - 1);
	localparam logic [31:0] OSC_LAST = 32'(OSC_CYC - 1);

	always_comb begin
		seq_next = seq_reg;
		cnt_next = cnt_reg + 32'h1;
		if (ev == RCI_EV_POWER_ON) begin
			cnt_next = 32'h0;
			if (pwrup_on)
				seq_next = RCI_ST_PWRUP;
			else if (crystal)
				seq_next = RCI_ST_OSC;
			else
				seq_next = RCI_ST_RUN;
		end else if (is_wake) begin
			cnt_next = 32'h0;
			seq_next = crystal ? RCI_ST_OSC : RCI_ST_RUN;
		end else begin
			unique case (seq_reg)
				RCI_ST_RUN: cnt_next = 32'h0;
				RCI_ST_PWRUP: if (cnt_reg >= PWRUP_LAST) begin
					cnt_next = 32'h0;
					seq_next = crystal ? RCI_ST_OSC : RCI_ST_RUN;
				end
				RCI_ST_OSC: if (cnt_reg >= OSC_LAST) begin
					cnt_next = 32'h0;
					seq_next = RCI_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		seq_reg <= seq_next;
		cnt_reg <= cnt_next;
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] flags_reg, int_ctrl_reg, core_set_reg, pb_dir_reg, pc_dir_reg;
	logic [7:0] accum_reg, timer_reg, pointer_reg, pb_data_reg, pc_data_reg;
	logic [4:0] pa_dir_reg, pa_data_reg;
	logic power_on_flag_reg, vec_reg, resume_reg;

	wire wr_hit = reg_wr & ~is_reset & ~is_wake;
	wire wr_flags = wr_hit & (reg_addr == `RCI_OFF_FLAGS);
	wire wr_pwr = wr_hit & (reg_addr == `RCI_OFF_PWR_CTRL);
	wire wr_int = wr_hit & (reg_addr == `RCI_OFF_INT_CTRL);
	wire wr_pcl = wr_hit & (reg_addr == `RCI_OFF_PC_LOW);
	wire wr_pch = wr_hit & (reg_addr == `RCI_OFF_PC_HIGH);
	wire global_interrupt_enable = int_ctrl_reg[`RCI_BIT_GIE];

	// flags: bits 4 and 3 are hardware owned, software writes the rest
	logic [7:0] flags_next;
	always_comb begin
		flags_next = flags_reg;
		if (wr_flags)
			flags_next = {reg_wdata[7:5], flags_reg[4:3], reg_wdata[2:0]};
		unique case (ev)
			RCI_EV_POWER_ON: flags_next = {3'h0, 2'b11, flags_reg[2:0]};
			RCI_EV_EXT_RUN: flags_next = {3'h0, flags_reg[4:0]};
			RCI_EV_EXT_SLEEP: flags_next = {3'h0, 2'b10, flags_reg[2:0]};
			RCI_EV_WDOG_RUN: flags_next = {4'h0, flags_reg[3:0]};
			RCI_EV_WDOG_WAKE: flags_next = {flags_reg[7:5], 2'b00, flags_reg[2:0]};
			RCI_EV_INT_WAKE: flags_next = {flags_reg[7:5], 2'b10, flags_reg[2:0]};
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		flags_reg <= flags_next;
		if (ev == RCI_EV_POWER_ON)
			power_on_flag_reg <= 1'b0;
		else if (wr_pwr)
			power_on_flag_reg <= reg_wdata[`RCI_BIT_POWER_ON];
		if (is_reset) begin
			pc_low <= `RCI_RST_PC_LOW;
			pc_high <= `RCI_RST_PC_HIGH;
			int_ctrl_reg <= {7'h00, int_ctrl_reg[0]};
			core_set_reg <= `RCI_RST_CORE_SET;
			pa_dir_reg <= `RCI_RST_PA_DIR;
			pb_dir_reg <= `RCI_RST_PB_DIR;
			pc_dir_reg <= `RCI_RST_PC_DIR;
			vec_reg <= 1'b0;
		end else if (is_wake) begin
			pc_low <= next_pc;
			int_ctrl_reg <= int_ctrl_reg | int_wake_flags;
			vec_reg <= (ev == RCI_EV_INT_WAKE) & global_interrupt_enable;
		end else begin
			if (wr_pcl)
				pc_low <= reg_wdata;
			if (wr_pch)
				pc_high <= reg_wdata[4:0];
			if (wr_int)
				int_ctrl_reg <= reg_wdata;
			if (wr_hit && reg_addr == `RCI_OFF_CORE_SET)
				core_set_reg <= reg_wdata;
			if (wr_hit && reg_addr == `RCI_OFF_PA_DIR)
				pa_dir_reg <= reg_wdata[4:0];
			if (wr_hit && reg_addr == `RCI_OFF_PB_DIR)
				pb_dir_reg <= reg_wdata;
			if (wr_hit && reg_addr == `RCI_OFF_PC_DIR)
				pc_dir_reg <= reg_wdata;
			// one instruction runs first, then the vector is taken
			if (vec_reg && seq_reg == RCI_ST_RUN && wr_pcl)
				vec_reg <= 1'b0;
		end
	end

	// data registers: no reset term at all, so every reset keeps them
	always_ff @(posedge clk) begin
		if (wr_hit && reg_addr == `RCI_OFF_ACCUM)
			accum_reg <= reg_wdata;
		if (wr_hit && reg_addr == `RCI_OFF_TIMER)
			timer_reg <= reg_wdata;
		if (wr_hit && reg_addr == `RCI_OFF_POINTER)
			pointer_reg <= reg_wdata;
		if (wr_hit && reg_addr == `RCI_OFF_PA_DATA)
			pa_data_reg <= reg_wdata[4:0];
		if (wr_hit && reg_addr == `RCI_OFF_PB_DATA)
			pb_data_reg <= reg_wdata;
		if (wr_hit && reg_addr == `RCI_OFF_PC_DATA)
			pc_data_reg <= reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// read port, one cycle latency
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			`RCI_OFF_ACCUM: rd_mux = accum_reg;
			`RCI_OFF_TIMER: rd_mux = timer_reg;
			`RCI_OFF_PC_LOW: rd_mux = pc_low;
			`RCI_OFF_FLAGS: rd_mux = flags_reg;
			`RCI_OFF_POINTER: rd_mux = pointer_reg;
			`RCI_OFF_PA_DATA: rd_mux = {3'h0, pa_data_reg};
			`RCI_OFF_PB_DATA: rd_mux = pb_data_reg;
			`RCI_OFF_PC_DATA: rd_mux = pc_data_reg;
			`RCI_OFF_PC_HIGH: rd_mux = {3'h0, pc_high};
			`RCI_OFF_INT_CTRL: rd_mux = int_ctrl_reg;
			`RCI_OFF_PIN_CFG: rd_mux = {5'h00, seq_reg != RCI_ST_RUN, osc_mode};
			`RCI_OFF_CORE_SET: rd_mux = core_set_reg;
			`RCI_OFF_PA_DIR: rd_mux = {3'h0, pa_dir_reg};
			`RCI_OFF_PB_DIR: rd_mux = pb_dir_reg;
			`RCI_OFF_PC_DIR: rd_mux = pc_dir_reg;
			`RCI_OFF_PWR_CTRL: rd_mux = {6'h00, power_on_flag_reg, 1'b0};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			core_hold <= 1'b1;
			resume_reg <= 1'b0;
			core_resume <= 1'b0;
			vector_pending <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
			core_hold <= (seq_next != RCI_ST_RUN) | is_reset;
			resume_reg <= is_wake;
			core_resume <= resume_reg;
			vector_pending <= vec_reg;
		end
	end

endmodule : rci_reset_init
`default_nettype wire

// ===== verif/rci_reset_init_monitor.sv
// assertion checker for the reset cause block
`timescale 1ns/10ps
`default_nettype none
module rci_reset_init_monitor
	import rci_pkg::*;
#(
	parameter longint PWRUP_CYC = 50,
	parameter int OSC_CYC = 1024
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// events and status
	input wire logic power_on_event,
	input wire logic external_reset_pin,
	input wire logic watchdog_event,
	input wire logic interrupt_wake,
	input wire logic core_sleeping,
	input wire logic [7:0] next_pc,
	input wire logic power_up_delay_select,
	input wire rci_osc_mode_t osc_mode,
	// register port and core control
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic core_hold,
	input wire logic core_resume,
	input wire logic [7:0] pc_low,
	input wire logic [4:0] pc_high,
	input wire logic vector_pending
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read reply");
	chk_pwr_unused: assert property ($past(reg_rd) && $past(reg_addr) == 8'h8E |-> (reg_rdata & 8'hFD) == 8'h00)
		else $error("unused power control bits not zero");
	chk_reset_state: assert property ($fell(sys_rst) |-> core_hold && pc_low == 8'h00 && pc_high == 5'h00)
		else $error("state after reset release wrong");
	chk_pwrup_hold: assert property ($fell(sys_rst) && !power_up_delay_select |-> core_hold [*8])
		else $error("core released before power-up delay");
	chk_ext_pc: assert property ($rose(external_reset_pin) |-> ##[2:8] pc_low == 8'h00)
		else $error("program counter not cleared by external reset");
	chk_wake_pc: assert property ($rose(watchdog_event) && core_sleeping |-> ##[2:8] pc_low == next_pc)
		else $error("program counter not loaded on watchdog wake");
	chk_wake_resume: assert property ($rose(interrupt_wake) && core_sleeping |-> ##[2:10] core_resume)
		else $error("no resume after interrupt wake");
	// clear lands in the flop behind vector_pending, so it shows two cycles on, and only once running
	chk_vector_clear: assert property (!core_hold && vector_pending && reg_wr && reg_addr == 8'h02 |-> ##2 !vector_pending)
		else $error("vector request not cleared by program counter write");
	chk_rc_nohold: assert property ($fell(power_on_event) && osc_mode == RCI_OSC_RES_CAP && power_up_delay_select
		|-> ##[1:8] !core_hold)
		else $error("delay applied in resistor-capacitor mode");
	cov_vector: cover property ($rose(vector_pending));
	cov_release: cover property ($fell(core_hold));
	cov_resume: cover property (core_resume);
endmodule : rci_reset_init_monitor
bind rci_reset_init rci_reset_init_monitor #(.PWRUP_CYC(PWRUP_CYC), .OSC_CYC(OSC_CYC)) u_monitor (.*);
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the reset cause block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rci_pkg::*;
	localparam int PW = 50;
	localparam int OS = 20;
	logic clk = 0, sys_rst = 1, pon = 0, ext = 0, wdg = 0, iwk = 0, slp = 0, pds = 0, wr = 0, rd = 0, rd_d = 0;
	logic [7:0] npc = 0, iwf = 0, addr = 0, wdat = 0, rdata, program_counter_low;
	logic [7:0] ra[3] = '{8'h01, 8'h04, 8'h0C};
	logic [7:0] rv[3];
	logic [7:0] exp_q[$], msk_q[$];
	logic [4:0] pch;
	logic hold, resume, vec;
	logic resume_seen = 0;
	rci_osc_mode_t osc = RCI_OSC_CRYSTAL;
	logic [31:0] seed = 32'hDF85;
	int fails = 0, total_checks = 0;
	rci_reset_init #(.PWRUP_CYC(PW), .OSC_CYC(OS)) DUT (.clk(clk), .sys_rst(sys_rst), .power_on_event(pon),
		.external_reset_pin(ext), .watchdog_event(wdg), .interrupt_wake(iwk), .core_sleeping(slp), .next_pc(npc),
		.int_wake_flags(iwf), .power_up_delay_select(pds), .osc_mode(osc), .reg_addr(addr), .reg_wdata(wdat),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .core_hold(hold), .core_resume(resume), .pc_low(program_counter_low),
		.pc_high(pch), .vector_pending(vec));
	initial forever #4 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// each strobe stands one cycle; callers chain calls so no signal is set twice per step
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdat <= d;
		@(posedge clk);
	endtask : bus
	task automatic idle(input int n);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (n - 1) @(posedge clk);
		#1;
	endtask : idle
	task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rreg
	task automatic fire(input int k);
		{pon, ext, wdg, iwk} <= 4'b1000 >> k;
		idle(4);
		{pon, ext, wdg, iwk} <= 4'b0000;
		idle(16);
	endtask : fire
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// read replies come back one cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd;
		if (resume)
			resume_seen <= 1'b1;
		if (rd_d && exp_q.size() > 0) check("reg_rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rreg(8'h8E, 8'h00);
		rreg(8'h03, 8'h18, 8'hF8);
		rreg(8'h0A, 8'h00);
		rreg(8'h0B, 8'h00, 8'hFE);
		rreg(8'h81, 8'hFF);
		rreg(8'h85, 8'h1F);
		rreg(8'h86, 8'hFF);
		rreg(8'h87, 8'hFF);
		rreg(8'h50, 8'h00);
		idle(PW + OS - 16);
		check("core_hold", {7'h00, hold}, 8'h01);
		idle(16);
		check("core_hold", {7'h00, hold}, 8'h00);
		$display("test reset values done");
		bus(1'b1, 1'b0, 8'h8E, 8'hFF);
		bus(1'b1, 1'b0, 8'h03, 8'hE7);
		rreg(8'h8E, 8'h02);
		rreg(8'h03, 8'h18, 8'h18);
		for (int i = 0; i < 3; i++) begin
			rv[i] = rnd();
			bus(1'b1, 1'b0, ra[i], rv[i]);
		end
		bus(1'b1, 1'b0, 8'h81, rnd());
		fire(1);
		for (int i = 0; i < 3; i++) rreg(ra[i], rv[i]);
		rreg(8'h81, 8'hFF);
		rreg(8'h8E, 8'h02);
		rreg(8'h03, 8'h18, 8'hF8);
		fire(2);
		rreg(8'h03, 8'h08, 8'hF8);
		bus(1'b1, 1'b0, 8'h02, 8'h5A);
		slp <= 1'b1;
		fire(1);
		rreg(8'h03, 8'h10, 8'hF8);
		$display("test resets done");
		npc <= rnd();
		rv[0] = rnd();
		bus(1'b1, 1'b0, 8'h81, rv[0]);
		bus(1'b1, 1'b0, 8'h0A, 8'h15);
		check("core_resume", {7'h00, resume_seen}, 8'h00);
		fire(2);
		check("core_resume", {7'h00, resume_seen}, 8'h01);
		check("core_hold", {7'h00, hold}, 8'h01);
		check("pc_low", program_counter_low, npc);
		check("pc_high", {3'b000, pch}, 8'h15);
		rreg(8'h81, rv[0]);
		rreg(8'h03, 8'h00, 8'h18);
		bus(1'b1, 1'b0, 8'h0B, 8'h80);
		iwf <= rnd() & 8'h7F;
		fire(3);
		check("vector_pending", {7'h00, vec}, 8'h01);
		rreg(8'h03, 8'h10, 8'h18);
		rreg(8'h0B, 8'h80 | iwf);
		// the vector request only clears once the oscillator delay is over
		idle(OS);
		bus(1'b1, 1'b0, 8'h02, 8'h00);
		idle(2);
		check("vector_pending", {7'h00, vec}, 8'h00);
		slp <= 1'b0;
		$display("test wakes done");
		fire(0);
		rreg(8'h8E, 8'h00);
		rreg(8'h03, 8'h18, 8'h18);
		osc <= RCI_OSC_RES_CAP;
		pds <= 1'b1;
		idle(PW + OS);
		fire(0);
		check("core_hold", {7'h00, hold}, 8'h00);
		$display("test power-on done");
		idle(2);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
